// file: src/tec_pkg.sv
// Package with register map, field layout and mode encodings of the timer.
package tec_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_COUNT   = 2'h1;
  localparam int         ADDR_W       = 2;
  localparam int         DATA_W       = 8;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int MODE_HI   = 7;
  localparam int MODE_LO   = 6;
  localparam int SRC_BIT   = 5;
  localparam int EN_BIT    = 4;
  localparam int EDGE_BIT  = 3;
  localparam int PSC_HI    = 2;
  localparam int PSC_LO    = 0;
  localparam int PSC_W     = 3;

  localparam logic [7:0] CONTROL_RESET = 8'h08;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] COUNT_FULL    = 8'hFF;

  // ----------------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TEC_MODE_UNUSED = 2'b00,
    TEC_MODE_EVENT  = 2'b01,
    TEC_MODE_TIMER  = 2'b10,
    TEC_MODE_PULSE  = 2'b11
  } tec_mode_t;

  // Decoded control register.
  typedef struct packed {
    tec_mode_t        mode;
    logic             src_sel;
    logic             enable;
    logic             edge_sel;
    logic [PSC_W-1:0] psc;
  } tec_ctrl_t;

  // Edge events of the synchronised event input.
  typedef struct packed {
    logic rise;
    logic fall;
    logic level;
  } tec_edges_t;

endpackage

// file: src/tec_prescaler.sv
// Clock source selection and power-of-two prescaler producing count ticks.
`timescale 1ns/10ps
module tec_prescaler #(
  parameter int PSC_W = 3
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Source clock ticks
  input  wire logic             i_sys_tick,
  input  wire logic             i_slow_tick,
  // Configuration
  input  wire logic             i_src_sel,
  input  wire logic [PSC_W-1:0] i_psc,
  input  wire logic             i_run,
  // Divided clock tick
  output logic                  o_tick
);

  localparam int DIV_W = (1 << PSC_W) - 1;

  initial begin
    if (PSC_W < 1 || PSC_W > 5) begin
      $error("tec_prescaler: PSC_W out of range");
    end
  end

  logic [DIV_W-1:0] div_count;
  logic [DIV_W-1:0] next_div_count;
  logic [DIV_W:0]   stage;
  wire              src_tick;

  // ----------------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------------
  assign src_tick = i_src_sel ? i_slow_tick : i_sys_tick; // RULE_03
  assign next_div_count = div_count + DIV_W'(1);

  // Stage n ticks on the high-to-low turn of divided clock bit n-1.
  assign stage[0] = src_tick;
  genvar g;
  generate
    for (g = 0; g < DIV_W; g++) begin : g_stage
      assign stage[g+1] = src_tick && div_count[g] && (&div_count[g:0]);
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      div_count <= '0;
    end else if (src_tick) begin
      div_count <= next_div_count;
    end
  end

  assign o_tick = i_run && stage[i_psc]; // RULE_04 RULE_17

endmodule

// file: src/tec_edge_sync.sv
// Two-stage synchroniser and edge detector for the event input pin.
`timescale 1ns/10ps
module tec_edge_sync (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // Event input pin
  input  wire logic                i_pin,
  // Detected edges
  output tec_pkg::tec_edges_t      o_edges
);

  logic meta;
  logic sync;
  logic last;

  // ----------------------------------------------------------------------
  // Synchroniser and edge detection
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= i_pin; // RULE_21
      sync <= meta;
      last <= sync;
    end
  end

  assign o_edges.rise  = sync && !last; // RULE_21
  assign o_edges.fall  = !sync && last;
  assign o_edges.level = sync;

endmodule

// file: src/tec_timer.sv
// Top of the 8-bit timer and event counter with its register port.
//
// How it works
// (RULE_01) Eight-bit up-counter, internal or pin clock.
// (RULE_02) Timer and capture modes use prescaled clock.
// (RULE_03) Source bit picks system or slow clock.
// (RULE_04) Prescale divides by two to field power.
// (RULE_05) Event mode counts selected pin edges.
// (RULE_06) Edge bit zero rising, one falling.
// (RULE_07) Capture edge bit sets start/stop polarity.
// (RULE_08) Mode codes: event, timer, capture, unused.
// (RULE_09) Counter runs only with enable set.
// (RULE_10) Read returns count; write goes via preload.
// (RULE_11) Overflow pulses, reloads preload, keeps counting.
// (RULE_12) Disabled: preload write loads counter now.
// (RULE_13) Enabled: preload waits for next overflow.
// (RULE_14) Event mode ignores source and prescale.
// (RULE_15) Software programs control before use.
// (RULE_16) Software clears preload for full range.
// (RULE_17) Timer counts on divided clock falling edge.
// (RULE_18) Capture waits for first active edge.
// (RULE_19) Capture end clears enable, holds width.
// (RULE_20) After auto stop, pin edges ignored.
// (RULE_21) Event pin synchronised before edge detection.
// (RULE_22) Unused mode holds count, no overflow.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module tec_timer #(
  parameter int PSC_W = 3
) (
  // Clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  // Clock source ticks, one cycle each
  input  wire logic                         i_sys_tick,
  input  wire logic                         i_slow_tick,
  // Event input pin
  input  wire logic                         i_event_pin,
  // Register port
  input  wire logic [tec_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [tec_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic      [tec_pkg::DATA_W-1:0]   o_rdata,
  // Status
  output logic                              o_overflow,
  output logic                              o_capturing
);

  initial begin
    if (PSC_W != tec_pkg::PSC_HI - tec_pkg::PSC_LO + 1) begin
      $error("tec_timer: PSC_W does not match the control layout");
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  tec_pkg::tec_ctrl_t          ctrl;
  tec_pkg::tec_ctrl_t          next_ctrl;
  logic [tec_pkg::DATA_W-1:0]  count;
  logic [tec_pkg::DATA_W-1:0]  next_count;
  logic [tec_pkg::DATA_W-1:0]  preload;
  logic                        active;
  logic                        next_active;
  logic                        overflow;
  tec_pkg::tec_edges_t         edges;

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  wire wr_ctrl  = i_wr && (i_addr == tec_pkg::ADDR_CONTROL);
  wire wr_count = i_wr && (i_addr == tec_pkg::ADDR_COUNT);
  wire rd_ctrl  = i_rd && (i_addr == tec_pkg::ADDR_CONTROL);
  wire rd_count = i_rd && (i_addr == tec_pkg::ADDR_COUNT);

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  wire mode_event = ctrl.mode == tec_pkg::TEC_MODE_EVENT;  // RULE_08
  wire mode_timer = ctrl.mode == tec_pkg::TEC_MODE_TIMER;  // RULE_08
  wire mode_pulse = ctrl.mode == tec_pkg::TEC_MODE_PULSE;  // RULE_08
  wire internal   = mode_timer || mode_pulse;              // RULE_02

  // ----------------------------------------------------------------------
  // Clock paths
  // ----------------------------------------------------------------------
  logic psc_tick;

  tec_prescaler #(
    .PSC_W (PSC_W)
  ) u_psc (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_sys_tick  (i_sys_tick),
    .i_slow_tick (i_slow_tick),
    .i_src_sel   (ctrl.src_sel),
    .i_psc       (ctrl.psc),
    .i_run       (ctrl.enable && internal),
    .o_tick      (psc_tick)
  );

  tec_edge_sync u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pin   (i_event_pin),
    .o_edges (edges)
  );

  // Event mode edge choice.
  wire ev_edge = ctrl.edge_sel ? edges.fall : edges.rise; // RULE_06
  // Capture start edge is the opposite sense of the event mode choice.
  wire start_edge = ctrl.edge_sel ? edges.rise : edges.fall; // RULE_07
  wire stop_edge  = ctrl.edge_sel ? edges.fall : edges.rise; // RULE_07

  // Capture begins on the start edge and ends on the return edge.
  wire pulse_start = mode_pulse && ctrl.enable && !active && start_edge;
  wire pulse_stop  = mode_pulse && ctrl.enable && active && stop_edge;

  // One count step per cycle at most.
  wire step_event = mode_event && ctrl.enable && ev_edge; // RULE_05 RULE_14
  wire step_timer = mode_timer && ctrl.enable && psc_tick; // RULE_17
  wire step_pulse = mode_pulse && ctrl.enable && active && psc_tick
                    && !pulse_stop; // RULE_18
  wire step = step_event || step_timer || step_pulse; // RULE_01 RULE_09
  wire wrap = step && (count == tec_pkg::COUNT_FULL); // RULE_22

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_ctrl   = ctrl;
    next_active = active;
    if (wr_ctrl) begin
      next_ctrl = tec_pkg::tec_ctrl_t'(i_wdata);
    end else if (pulse_stop) begin
      next_ctrl.enable = 1'b0; // RULE_19
    end
    if (!mode_pulse || !next_ctrl.enable) begin
      next_active = 1'b0; // RULE_20
    end else if (pulse_start) begin
      next_active = 1'b1; // RULE_18
    end
  end

  always_comb begin
    next_count = count;
    if (wrap) begin
      next_count = preload; // RULE_11 RULE_13
    end else if (step) begin
      next_count = count + 8'h01; // RULE_01
    end
    if (wr_count && !ctrl.enable) begin
      next_count = i_wdata; // RULE_12
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl     <= tec_pkg::tec_ctrl_t'(tec_pkg::CONTROL_RESET);
      count    <= tec_pkg::COUNT_RESET;
      preload  <= tec_pkg::COUNT_RESET;
      active   <= 1'b0;
      overflow <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      count    <= next_count;
      active   <= next_active;
      overflow <= wrap; // RULE_11
      if (wr_count) begin
        preload <= i_wdata; // RULE_10 RULE_13
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  wire [tec_pkg::DATA_W-1:0] ctrl_bits = ctrl;
  wire [tec_pkg::DATA_W-1:0] rd_mux = rd_ctrl  ? ctrl_bits :
                                      rd_count ? count : // RULE_10
                                      '0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= rd_mux;
    end
  end

  assign o_overflow  = overflow;
  assign o_capturing = active;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_wrap_reload: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_11
    (wrap && !(wr_count && !ctrl.enable)) |=> (count == $past(preload)))
    else $error("Overflow did not reload the preload value.");

  chk_overflow_pulse: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_11
    o_overflow |-> $past(count) == tec_pkg::COUNT_FULL)
    else $error("Overflow raised below full count.");

  chk_disabled_load: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_12
    (wr_count && !ctrl.enable) |=> (count == $past(i_wdata)))
    else $error("Disabled preload write did not reach the counter.");

  chk_enabled_hold: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_13
    (wr_count && ctrl.enable && !step) |=> (count == $past(count)))
    else $error("Enabled preload write changed the counter.");

  chk_unused_hold: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_22
    (ctrl.mode == tec_pkg::TEC_MODE_UNUSED && !wr_count) |=>
      (count == $past(count) && !o_overflow))
    else $error("Unused mode changed the counter.");

  chk_stop_disable: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_19
    (pulse_stop && !wr_ctrl) |=> (!ctrl.enable && !active))
    else $error("Capture end did not clear the enable bit.");

  chk_enable_gate: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_09
    (!ctrl.enable && !wr_count) |=> (count == $past(count)))
    else $error("Counter moved while disabled.");

  chk_event_count: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_05
    (mode_event && ctrl.enable && ev_edge && !wr_count &&
     count != tec_pkg::COUNT_FULL) |=> (count == $past(count) + 8'h01))
    else $error("Event edge did not advance the counter.");

  chk_pulse_wait: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_18
    (mode_pulse && !active && !wr_count) |=> (count == $past(count)))
    else $error("Capture counted before the start edge.");

  chk_read_data: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_10
    rd_count |=> (o_rdata == $past(count)))
    else $error("Count read returned the wrong value.");

  chk_read_idle: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_10
    !i_rd |=> (o_rdata == '0))
    else $error("Read data stood outside a read.");

  chk_capture_start: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_18
    (!active && !pulse_start) |=> !active)
    else $error("Capture began without a start edge.");

  chk_timer_gate: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_17
    (mode_timer && !psc_tick && !wr_count) |=> (count == $past(count)))
    else $error("Timer moved without a divided clock tick.");

  chk_pulse_step: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_02
    (step_pulse && !wr_count && count != tec_pkg::COUNT_FULL) |=>
      (count == $past(count) + 8'h01))
    else $error("Capture tick did not advance the counter.");

  chk_stop_ignore: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_20
    (mode_pulse && !ctrl.enable && !wr_ctrl) |=> !active)
    else $error("Capture restarted while disabled.");

endmodule

// file: tb/tec_pin_model.sv
// Behavioural source of events and pulses on the timer input pin.
`timescale 1ns/10ps
module tec_pin_model (
  // Clock
  input  wire logic i_clk,
  // Event pin
  output logic      o_pin
);
  logic idle = 1'b0;

  initial o_pin = 1'b0;

  // Moves the resting level of the pin and lets it settle.
  task automatic rest(input logic lvl);
    @(posedge i_clk);
    idle = lvl;
    o_pin <= lvl;
    repeat (4) @(posedge i_clk);
  endtask

  // Drives one pulse away from the resting level, then waits.
  task automatic pulse(input int width, input int gap);
    @(posedge i_clk);
    o_pin <= ~idle;
    repeat (width) @(posedge i_clk);
    o_pin <= idle;
    repeat (gap) @(posedge i_clk);
  endtask
endmodule

// file: tb/tec_timer_test.sv
// Self-checking testbench of the timer and event counter.
`timescale 1ns/10ps
module tec_timer_test;
  localparam int LIMIT = 20000;
  localparam logic [1:0] CT = tec_pkg::ADDR_CONTROL;
  localparam logic [1:0] CN = tec_pkg::ADDR_COUNT;
  logic       i_clk, i_rst, i_sys_tick, i_slow_tick, pin, i_wr, i_rd;
  logic       o_overflow, o_capturing;
  logic [1:0] i_addr;
  logic [7:0] i_wdata, o_rdata, rv, ovf_seen, pre;
  int         failures = 0, checks_done = 0, cycles = 0, seed = 7917;
  int         n, w;

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  tec_timer #(.PSC_W(3)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_sys_tick(i_sys_tick),
    .i_slow_tick(i_slow_tick), .i_event_pin(pin), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_overflow(o_overflow), .o_capturing(o_capturing));
  tec_pin_model u_src (.i_clk(i_clk), .o_pin(pin));

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      summarize();
    end
  end

  always @(posedge i_clk)
    if (i_rst) ovf_seen <= 8'h00;
    else if (o_overflow === 1'b1) ovf_seen <= ovf_seen + 8'h01;

  task automatic summarize();
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_near(input logic [7:0] got, input logic [7:0] exp,
                          input int tol);
    checks_done++;
    if ($isunknown(got) || int'(got) > int'(exp) + tol ||
        int'(got) + tol < int'(exp)) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic ticks(input logic slow, input int k);
    repeat (k) begin
      @(posedge i_clk);
      if (slow) i_slow_tick <= 1'b1;
      else i_sys_tick <= 1'b1;
      @(posedge i_clk);
      i_slow_tick <= 1'b0;
      i_sys_tick <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
  endtask

  function automatic logic [7:0] ctl(input logic [1:0] m, input logic s,
                                     input logic e, input logic g,
                                     input logic [2:0] p);
    return {m, s, e, g, p};
  endfunction

  initial begin
    i_rst = 1'b1;
    i_sys_tick = 1'b0;
    i_slow_tick = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 2'h0;
    i_wdata = 8'h00;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(CT, rv); cmp8(rv, 8'h08);
    rd(CN, rv); cmp8(rv, 8'h00);
    wr(2'h2, 8'hFF);
    rd(2'h2, rv); cmp8(rv, 8'h00);
    rd(CT, rv); cmp8(rv, 8'h08);
    for (int k = 0; k < 8; k++) begin
      wr(CT, ctl(tec_pkg::TEC_MODE_TIMER, 1'b0, 1'b0, 1'b0, 3'(k)));
      wr(CN, 8'h00);
      wr(CT, ctl(tec_pkg::TEC_MODE_TIMER, 1'b0, 1'b1, 1'b0, 3'(k)));
      ticks(1'b0, 4 << k);
      rd(CN, rv); cmp_near(rv, 8'h04, 1);
    end
    wr(CT, ctl(tec_pkg::TEC_MODE_TIMER, 1'b1, 1'b0, 1'b0, 3'h0));
    wr(CN, 8'h10);
    wr(CT, ctl(tec_pkg::TEC_MODE_TIMER, 1'b1, 1'b1, 1'b0, 3'h0));
    ticks(1'b0, 5);
    rd(CN, rv); cmp8(rv, 8'h10);
    ticks(1'b1, 5);
    rd(CN, rv); cmp8(rv, 8'h15);
    wr(CT, ctl(tec_pkg::TEC_MODE_TIMER, 1'b1, 1'b0, 1'b0, 3'h0));
    ticks(1'b1, 3);
    rd(CN, rv); cmp8(rv, 8'h15);
    for (int g = 0; g < 2; g++) begin
      pre = 8'($random(seed)) & 8'h7F;
      n = 1 + {$random(seed)} % 8;
      wr(CT, ctl(tec_pkg::TEC_MODE_EVENT, 1'b1, 1'b0, 1'(g), 3'h7));
      wr(CN, pre);
      wr(CT, ctl(tec_pkg::TEC_MODE_EVENT, 1'b1, 1'b1, 1'(g), 3'h7));
      repeat (n) u_src.pulse(2, 2);
      u_src.rest(1'b1);
      rd(CN, rv); cmp8(rv, 8'(pre + n + (g == 0)));
      u_src.rest(1'b0);
    end
    wr(CT, ctl(tec_pkg::TEC_MODE_EVENT, 1'b0, 1'b0, 1'b0, 3'h0));
    wr(CN, 8'hFD);
    wr(CT, ctl(tec_pkg::TEC_MODE_EVENT, 1'b0, 1'b1, 1'b0, 3'h0));
    wr(CN, 8'h40);
    rd(CN, rv); cmp8(rv, 8'hFD);
    pre = ovf_seen;
    repeat (3) u_src.pulse(2, 3);
    repeat (6) @(posedge i_clk);
    rd(CN, rv); cmp8(rv, 8'h40);
    cmp8(ovf_seen, pre + 8'h01);
    wr(CT, ctl(tec_pkg::TEC_MODE_UNUSED, 1'b0, 1'b0, 1'b0, 3'h0));
    wr(CN, 8'hFF);
    wr(CT, ctl(tec_pkg::TEC_MODE_UNUSED, 1'b0, 1'b1, 1'b0, 3'h0));
    pre = ovf_seen;
    ticks(1'b0, 4);
    repeat (3) u_src.pulse(2, 2);
    repeat (6) @(posedge i_clk);
    rd(CN, rv); cmp8(rv, 8'hFF);
    cmp8(ovf_seen, pre);
    for (int g = 0; g < 2; g++) begin
      u_src.rest(1'(g == 0));
      w = 8 + {$random(seed)} % 32;
      i_sys_tick <= 1'b1;
      wr(CT, ctl(tec_pkg::TEC_MODE_PULSE, 1'b0, 1'b0, 1'(g), 3'h0));
      wr(CN, 8'h00);
      wr(CT, ctl(tec_pkg::TEC_MODE_PULSE, 1'b0, 1'b1, 1'(g), 3'h0));
      repeat (10) @(posedge i_clk);
      rd(CN, rv); cmp8(rv, 8'h00);
      fork
        u_src.pulse(w, 8);
        begin
          repeat (w / 2 + 3) @(posedge i_clk);
          #1 cmp8({7'h00, o_capturing}, 8'h01);
        end
      join
      rd(CT, rv);
      cmp8(rv, ctl(tec_pkg::TEC_MODE_PULSE, 1'b0, 1'b0, 1'(g),
                   3'h0));
      cmp8({7'h00, o_capturing}, 8'h00);
      rd(CN, rv); cmp_near(rv, 8'(w), 3);
      pre = rv;
      u_src.pulse(5, 8);
      rd(CN, rv); cmp8(rv, pre);
      i_sys_tick <= 1'b0;
    end
    summarize();
  end
endmodule
